//--- clock_stretch.sv
// Contract
// - Clearing release bit: wait for clock low, then hold it low.
// - Setting release bit stops holding the clock low.
// - Acknowledged read address clears the release bit.
// - With stretch enable, every acknowledge clears the release bit.
// - Buffer-full flag never affects stretching.
// - Read request stretches even if transmit buffer already loaded.
// - Address-update flag stretches without clearing the release bit.
// - Writing slave address register ends the address-update stretch at once.
// - Address hold clears release bit after 8th fall of matching address.
// - Data hold clears release bit after 8th fall of each data byte.
// - Clock only driven low after being sampled low.
// - Hold clock low until release bit set; line rises when all release.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module clock_stretch
  import stretch_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register port
  input  wire reg_req_t   req,
  output var  logic [7:0] rdata,
  // Serial engine events
  input  wire bus_event_t evt,
  input  wire logic       buffer_full_flag,
  // Serial clock pin, open drain
  input  wire logic       scl_in,
  output var  logic       scl_out,
  output var  logic       scl_oe,
  // Visible state
  output var  logic       clock_release_bit,
  output var  logic       address_update_flag
);

  ////////////////////////////////////////////////////////////////////////
  logic       scl_sync;
  logic       scl_prev;
  logic       scl_fall;
  logic       stretch_enable;
  logic       address_hold_enable;
  logic       data_hold_enable;
  logic [7:0] slave_address_reg;
  logic       holding;
  logic       hw_clear;
  logic       sw_set;
  logic       sw_clear;
  logic       adr_write;
  logic       want_low;

  sync2 u_scl_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (scl_in),
    .dout    (scl_sync)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev <= 1'b1;
    end else begin
      scl_prev <= scl_sync;
    end
  end

  assign scl_fall = scl_prev & ~scl_sync;

  ////////////////////////////////////////////////////////////////////////
  // Software side
  assign sw_set    = req.wr && req.addr == ADDR_CONTROL && req.wdata[CTL_RELEASE];
  assign sw_clear  = req.wr && req.addr == ADDR_CONTROL && !req.wdata[CTL_RELEASE];
  assign adr_write = req.wr && req.addr == ADDR_SLAVE_ADR;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stretch_enable      <= CONTROL_RESET[CTL_STRETCH];
      address_hold_enable <= CONTROL_RESET[CTL_ADR_HOLD];
      data_hold_enable    <= CONTROL_RESET[CTL_DAT_HOLD];
    end else if (req.wr && req.addr == ADDR_CONTROL) begin
      stretch_enable      <= req.wdata[CTL_STRETCH];
      address_hold_enable <= req.wdata[CTL_ADR_HOLD];
      data_hold_enable    <= req.wdata[CTL_DAT_HOLD];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slave_address_reg <= 8'h00;
    end else if (adr_write) begin
      slave_address_reg <= req.wdata;
    end
  end

  // Buffer-full flag only shown, never steers the stretch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_CONTROL:   rdata <= {4'h0, data_hold_enable, address_hold_enable,
                                  stretch_enable, clock_release_bit};
        ADDR_SLAVE_ADR: rdata <= slave_address_reg;
        ADDR_STATUS:    rdata <= {4'h0, buffer_full_flag, address_update_flag,
                                  scl_sync, holding};
        default:        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Release bit: hardware clear beats a software set in the same cycle
  assign hw_clear = evt.ack_read
                  | (evt.ack_done & stretch_enable)
                  | (evt.addr_8th & address_hold_enable)
                  | (evt.data_8th & data_hold_enable);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clock_release_bit <= CONTROL_RESET[CTL_RELEASE];
    end else if (hw_clear) begin
      clock_release_bit <= 1'b0;
    end else if (sw_set) begin
      clock_release_bit <= 1'b1;
    end else if (sw_clear) begin
      clock_release_bit <= 1'b0;
    end
  end

  // Address-update stretch, set wins over the releasing write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      address_update_flag <= 1'b0;
    end else if (evt.addr_update) begin
      address_update_flag <= 1'b1;
    end else if (adr_write) begin
      address_update_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pull-down only after line seen low, so high time is never cut short
  assign want_low = !clock_release_bit || address_update_flag;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holding <= 1'b0;
    end else if (!want_low) begin
      holding <= 1'b0;
    end else if (!scl_sync) begin
      holding <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe  <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      scl_oe  <= want_low && (holding || !scl_sync);
      scl_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_no_drive_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(scl_oe) |-> $past(!scl_sync))
    else $error("clock pulled low before it was seen low");
  a_release_drops: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (clock_release_bit && !address_update_flag) |=> !scl_oe)
    else $error("clock still held after release");
  a_read_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
    evt.ack_read |=> !clock_release_bit)
    else $error("read acknowledge did not clear release bit");
  a_ack_stretch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.ack_done && stretch_enable) |=> !clock_release_bit)
    else $error("acknowledge with stretch enable not stretched");
  a_buf_ignored: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.ack_read && buffer_full_flag) |=> !clock_release_bit)
    else $error("buffer flag suppressed stretch");
  a_update_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.addr_update && !hw_clear && !req.wr) |=> $stable(clock_release_bit) && address_update_flag)
    else $error("address update changed release bit");
  a_adr_write_ends: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (adr_write && !evt.addr_update && clock_release_bit && !hw_clear && !sw_clear)
      |=> !address_update_flag ##1 !scl_oe)
    else $error("slave address write did not release clock");
  a_adr_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.addr_8th && address_hold_enable) |=> !clock_release_bit)
    else $error("address hold did not clear release bit");
  a_data_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (evt.data_8th && data_hold_enable) |=> !clock_release_bit)
    else $error("data hold did not clear release bit");
  a_hold_stays: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (scl_oe && !clock_release_bit && !sw_set) |=> scl_oe)
    else $error("hold dropped without release");
  a_open_drain: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !scl_out)
    else $error("clock driven high");

  c_read_stretch: cover property (@(posedge clk_sys) disable iff (!arst_n)
    evt.ack_read ##[1:20] scl_oe);
  c_update_end: cover property (@(posedge clk_sys) disable iff (!arst_n)
    address_update_flag && scl_oe ##1 adr_write);
  c_release: cover property (@(posedge clk_sys) disable iff (!arst_n)
    scl_oe ##1 sw_set ##2 !scl_oe);
  c_fall_seen: cover property (@(posedge clk_sys) disable iff (!arst_n)
    scl_fall && !clock_release_bit);

endmodule
`default_nettype wire

//--- stretch_pkg.sv
`default_nettype none
package stretch_pkg;

  // Register port map (word addresses on the plain register port)
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_SLAVE_ADR = 4'h1;
  localparam logic [3:0] ADDR_STATUS    = 4'h2;

  // Control register field positions
  localparam int CTL_RELEASE  = 0;
  localparam int CTL_STRETCH  = 1;
  localparam int CTL_ADR_HOLD = 2;
  localparam int CTL_DAT_HOLD = 3;

  // Control register reset value: clock released, all stretching off
  localparam logic [7:0] CONTROL_RESET = 8'h01;

  // Status register field positions
  localparam int STS_HOLDING = 0;
  localparam int STS_SCL     = 1;
  localparam int STS_UPDATE  = 2;
  localparam int STS_BUF     = 3;

  // Bus events from the serial engine, one-cycle pulses
  typedef struct packed {
    logic ack_read;
    logic ack_done;
    logic addr_8th;
    logic data_8th;
    logic addr_update;
  } bus_event_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage
`default_nettype wire

//--- sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Data
  input  wire logic din,
  output var  logic dout
);
  logic meta;

  // Line idles high, so both stages reset to one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

//--- scl_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module scl_master_model (
  // Wired clock line
  input  wire logic scl_line,
  // Frame control
  input  wire logic run,
  output var  logic scl_low
);
  // Clock stands still between frames
  initial scl_low = 1'b0;
  always begin
    wait (run);
    #100 scl_low = 1'b1;
    #100 scl_low = 1'b0;
    // A stretched line keeps the next low phase waiting
    wait (scl_line);
  end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import stretch_pkg::*;
();
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  reg_req_t   req = '0;
  bus_event_t evt = '0;
  logic       buffer_full_flag = 1'b1;
  logic       run = 1'b0;
  logic [7:0] rdata;
  logic       scl_out, scl_oe, clock_release_bit, address_update_flag, m_low, scl_line;
  int         n_errors = 0;
  int         total_checks = 0;
  // Event select 5 means none: software clear
  int         ev_sel[8] = '{4, 3, 3, 2, 1, 1, 0, 5};
  logic [7:0] ctl_v[8] = '{8'h01, 8'h03, 8'h01, 8'h05, 8'h09, 8'h01, 8'h01, 8'h00};
  logic       rel_v[8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic       upd_v[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  // Pull-up on the wired line
  assign scl_line = !(m_low || (scl_oe && !scl_out));

  always #12.5 clk_sys = ~clk_sys;

  clock_stretch clock_stretch_i (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .rdata(rdata), .evt(evt),
    .buffer_full_flag(buffer_full_flag), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .clock_release_bit(clock_release_bit), .address_update_flag(address_update_flag));
  scl_master_model scl_master_model_i (.scl_line(scl_line), .run(run), .scl_low(m_low));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 chk("rdata", rdata, exp);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic run_row(input int r);
    int   i;
    logic stretch;
    logic bf;
    stretch = !rel_v[r] || upd_v[r];
    // Flag alternates between rows; it must never change the outcome
    bf = !r[0];
    buffer_full_flag <= bf;
    wr(ADDR_CONTROL, ctl_v[r]);
    @(posedge clk_sys);
    evt <= bus_event_t'(5'h01 << ev_sel[r]);
    @(posedge clk_sys);
    evt <= '0;
    repeat (10) @(posedge clk_sys);
    #1 chk("release", clock_release_bit, rel_v[r]);
    chk("update", address_update_flag, upd_v[r]);
    chk("oe idle", scl_oe, 1'b0);
    rd(ADDR_CONTROL, {ctl_v[r][7:1], rel_v[r]});
    run = 1'b1;
    for (i = 0; i < 100 && scl_oe !== 1'b1; i++) @(posedge clk_sys);
    run = 1'b0;
    #1 chk("oe hold", scl_oe, stretch);
    repeat (20) @(posedge clk_sys);
    if (stretch) begin
      #1 chk("line held", scl_line, 1'b0);
      chk("drive level", scl_out, 1'b0);
      rd(ADDR_STATUS, {4'h0, bf, upd_v[r], 2'b01});
      if (upd_v[r]) wr(ADDR_SLAVE_ADR, 8'h5a);
      else wr(ADDR_CONTROL, ctl_v[r] | 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 chk("oe freed", scl_oe, 1'b0);
    end
    for (i = 0; i < 100 && scl_line !== 1'b1; i++) @(posedge clk_sys);
    chk("line free", scl_line, 1'b1);
    $display("test row %0d done", r);
  endtask

  initial begin
    #2000000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_STATUS, 8'h0a);
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 8; r++) run_row(r);
    rd(ADDR_SLAVE_ADR, 8'h5a);
    close_out();
  end
endmodule
`default_nettype wire
